// ---- scfms_sequencer.sv ----
// supercap charge and flash mode sequencer
`timescale 1ns/1ps
`include "scfms_regs.svh"
module scfms_sequencer #(
  parameter int PWM_WIDTH = 8,
  parameter int TICK_CYCLES = `SCFMS_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [2:0] mode_in,
  input wire logic mode_write,
  input wire logic [1:0] post_burst_mode,
  input wire logic [1:0] fill_rate,
  input wire logic [2:0] boost1_inductor_limit,
  input wire logic maintain_cap_topup,
  input wire logic balancer_override,
  input wire logic full_irq_enable,
  input wire logic full_flag_clear,
  input wire logic [PWM_WIDTH-1:0] lamp_duty,
  input wire logic [7:0] flash_max_ticks,
  input wire logic cap_near_input,
  input wire logic cap_at_input,
  input wire logic cap_at_full,
  input wire logic cap_below_input_margin,
  input wire logic cap_over_limit,
  input wire logic boost_node_high,
  input wire logic boost_node_low,
  input wire logic cap_under_flash_min,
  input wire logic hot_die_threshold,
  input wire logic hot_die_cleared,
  input wire logic flash_stop,
  output logic [2:0] mode_out,
  output logic [3:0] state_out,
  output logic precharge_switch,
  output logic precharge_low_power,
  output logic [1:0] fill_rate_out,
  output logic boost1_on,
  output logic boost2_on,
  output logic [2:0] boost1_peak,
  output logic charge_source_on,
  output logic output_switch,
  output logic keep_source_on,
  output logic topup_5ma_on,
  output logic bleed_resistor_path,
  output logic balancer_on,
  output logic lamp_on,
  output logic full_flag,
  output logic int_n,
  output logic hot_paused
);
  scfms_pkg::scfms_state_e state_r;
  scfms_pkg::scfms_state_e state_nxt;
  logic [2:0] mode_r;
  logic [2:0] mode_nxt;
  logic first_full_r;
  logic first_full_nxt;
  logic hot_r;
  logic hot_nxt;
  logic flag_r;
  logic b2_cut_r;
  logic flash_expired;
  logic pwm_lamp;
  logic flash_end;
  logic charge_done;
  logic charging_phase;
  logic lamp_mode;
  logic topup_need;
  logic over_bleed;
  logic [2:0] after_flash_mode;

  assign after_flash_mode = (post_burst_mode == 2'h0) ? `SCFMS_MODE_SHDN_KEEP :
                            (post_burst_mode == 2'h1) ? `SCFMS_MODE_SHDN_DIS :
                            (post_burst_mode == 2'h2) ? `SCFMS_MODE_PRECHARGE :
                            `SCFMS_MODE_CHARGE;
  assign flash_end = (state_r == scfms_pkg::SCFMS_ST_FLASH) && (flash_expired || flash_stop);
  assign mode_nxt = flash_end ? after_flash_mode : (mode_write ? mode_in : mode_r);

  assign charging_phase = (state_r == scfms_pkg::SCFMS_ST_PRECHARGE) ||
                          (state_r == scfms_pkg::SCFMS_ST_TRANSITION) ||
                          (state_r == scfms_pkg::SCFMS_ST_CHARGE);
  assign hot_nxt = charging_phase ? (hot_r ? !hot_die_cleared : hot_die_threshold) : 1'b0;
  assign charge_done = (state_r == scfms_pkg::SCFMS_ST_CHARGE) && !hot_r &&
                       first_full_r && cap_at_full;
  assign first_full_nxt = (state_r != scfms_pkg::SCFMS_ST_CHARGE) ? 1'b0 :
                          (cap_at_full ? 1'b1 : first_full_r);
  assign lamp_mode = (state_r == scfms_pkg::SCFMS_ST_TORCH) ||
                     (state_r == scfms_pkg::SCFMS_ST_PWM);
  assign topup_need = maintain_cap_topup && !cap_at_full;
  assign over_bleed = cap_over_limit;

  always_comb begin
    state_nxt = state_r;
    case (mode_r)
      `SCFMS_MODE_SHDN_KEEP: begin
        if (state_r == scfms_pkg::SCFMS_ST_SHDN_BLEED)
          state_nxt = boost_node_low ? scfms_pkg::SCFMS_ST_SHDN : state_r;
        else if (state_r != scfms_pkg::SCFMS_ST_SHDN)
          state_nxt = boost_node_high ? scfms_pkg::SCFMS_ST_SHDN_BLEED : scfms_pkg::SCFMS_ST_SHDN;
      end
      `SCFMS_MODE_SHDN_DIS: state_nxt = scfms_pkg::SCFMS_ST_DISCH;
      `SCFMS_MODE_PRECHARGE: begin
        case (state_r)
          scfms_pkg::SCFMS_ST_PRECHARGE: state_nxt = state_r;
          scfms_pkg::SCFMS_ST_PRE_BLEED:
            state_nxt = cap_below_input_margin ? scfms_pkg::SCFMS_ST_PRECHARGE : state_r;
          scfms_pkg::SCFMS_ST_CHARGE, scfms_pkg::SCFMS_ST_EOC, scfms_pkg::SCFMS_ST_KEEP,
          scfms_pkg::SCFMS_ST_FLASH:
            state_nxt = scfms_pkg::SCFMS_ST_PRE_BLEED;
          default: state_nxt = scfms_pkg::SCFMS_ST_PRECHARGE;
        endcase
      end
      `SCFMS_MODE_CHARGE: begin
        case (state_r)
          scfms_pkg::SCFMS_ST_TRANSITION:
            state_nxt = (!hot_r && cap_at_input) ? scfms_pkg::SCFMS_ST_CHARGE : state_r;
          scfms_pkg::SCFMS_ST_CHARGE:
            state_nxt = charge_done ? scfms_pkg::SCFMS_ST_EOC : state_r;
          scfms_pkg::SCFMS_ST_EOC:
            state_nxt = maintain_cap_topup ? scfms_pkg::SCFMS_ST_KEEP : state_r;
          scfms_pkg::SCFMS_ST_KEEP:
            state_nxt = maintain_cap_topup ? state_r : scfms_pkg::SCFMS_ST_EOC;
          scfms_pkg::SCFMS_ST_PRECHARGE:
            state_nxt = (!hot_r && cap_near_input) ? scfms_pkg::SCFMS_ST_TRANSITION : state_r;
          default:
            state_nxt = cap_at_input ? scfms_pkg::SCFMS_ST_CHARGE :
                        (cap_near_input ? scfms_pkg::SCFMS_ST_TRANSITION :
                         scfms_pkg::SCFMS_ST_PRECHARGE);
        endcase
      end
      `SCFMS_MODE_TORCH: state_nxt = scfms_pkg::SCFMS_ST_TORCH;
      `SCFMS_MODE_PWM: state_nxt = scfms_pkg::SCFMS_ST_PWM;
      `SCFMS_MODE_FLASH: state_nxt = scfms_pkg::SCFMS_ST_FLASH;
      default: state_nxt = scfms_pkg::SCFMS_ST_SHDN;
    endcase
    if (flash_end) begin
      if (after_flash_mode == `SCFMS_MODE_PRECHARGE)
        state_nxt = scfms_pkg::SCFMS_ST_PRE_BLEED;
      else if (after_flash_mode == `SCFMS_MODE_SHDN_KEEP && boost_node_high)
        state_nxt = scfms_pkg::SCFMS_ST_SHDN_BLEED;
      else
        state_nxt = scfms_pkg::SCFMS_ST_SHDN;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= scfms_pkg::SCFMS_ST_SHDN;
      mode_r <= `SCFMS_MODE_SHDN_KEEP;
      first_full_r <= 1'b0;
      hot_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      first_full_r <= first_full_nxt;
      hot_r <= hot_nxt;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (charge_done) begin
      flag_r <= 1'b1;
    end else if (full_flag_clear) begin
      flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      b2_cut_r <= 1'b0;
    end else if (state_r != scfms_pkg::SCFMS_ST_FLASH) begin
      b2_cut_r <= 1'b0;
    end else if (cap_under_flash_min) begin
      b2_cut_r <= 1'b1;
    end
  end

  scfms_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .run(state_r == scfms_pkg::SCFMS_ST_FLASH),
    .limit(flash_max_ticks),
    .expired(flash_expired)
  );

  scfms_pwm #(
    .WIDTH(PWM_WIDTH)
  ) u_pwm (
    .clock(clock),
    .rst_n(rst_n),
    .enable(state_r == scfms_pkg::SCFMS_ST_PWM),
    .duty(lamp_duty),
    .lamp_on(pwm_lamp)
  );

  logic b1_nxt;
  logic b2_nxt;
  logic [2:0] peak_nxt;
  logic csrc_nxt;
  logic osw_nxt;
  logic keep_nxt;
  logic top5_nxt;
  logic bleed_nxt;
  logic bal_nxt;
  logic lamp_nxt;
  logic psw_nxt;
  logic lowp_nxt;
  logic active_charge;
  assign active_charge = charging_phase && !hot_r;
  assign psw_nxt = active_charge && (state_r == scfms_pkg::SCFMS_ST_PRECHARGE);
  assign lowp_nxt = psw_nxt && (fill_rate == `SCFMS_FILL_LOW_POWER);
  assign b1_nxt = (active_charge && (state_r != scfms_pkg::SCFMS_ST_PRECHARGE)) ||
                  lamp_mode || (state_r == scfms_pkg::SCFMS_ST_FLASH) ||
                  (state_r == scfms_pkg::SCFMS_ST_KEEP && topup_need);
  assign b2_nxt = (state_r == scfms_pkg::SCFMS_ST_FLASH) && !b2_cut_r && !cap_under_flash_min;
  assign csrc_nxt = active_charge && (state_r != scfms_pkg::SCFMS_ST_CHARGE);
  assign osw_nxt = active_charge && (state_r == scfms_pkg::SCFMS_ST_CHARGE);
  assign peak_nxt = (osw_nxt && first_full_r) ? `SCFMS_PEAK_REDUCED : boost1_inductor_limit;
  assign keep_nxt = lamp_mode && topup_need;
  assign top5_nxt = (state_r == scfms_pkg::SCFMS_ST_KEEP) && topup_need;
  assign bleed_nxt = over_bleed || (state_r == scfms_pkg::SCFMS_ST_DISCH) ||
                     (state_r == scfms_pkg::SCFMS_ST_PRE_BLEED) ||
                     (state_r == scfms_pkg::SCFMS_ST_SHDN_BLEED);
  assign bal_nxt = charging_phase || (state_r == scfms_pkg::SCFMS_ST_KEEP) ||
                   (state_r == scfms_pkg::SCFMS_ST_EOC) ||
                   (state_r == scfms_pkg::SCFMS_ST_DISCH) ||
                   (state_r == scfms_pkg::SCFMS_ST_PRE_BLEED) ||
                   (state_r == scfms_pkg::SCFMS_ST_SHDN_BLEED) || balancer_override;
  assign lamp_nxt = (state_r == scfms_pkg::SCFMS_ST_TORCH) ||
                    (state_r == scfms_pkg::SCFMS_ST_FLASH) || pwm_lamp;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      precharge_switch <= 1'b0;
      precharge_low_power <= 1'b0;
      boost1_on <= 1'b0;
      boost2_on <= 1'b0;
      boost1_peak <= 3'h0;
      charge_source_on <= 1'b0;
      output_switch <= 1'b0;
      keep_source_on <= 1'b0;
      topup_5ma_on <= 1'b0;
      bleed_resistor_path <= 1'b0;
      balancer_on <= 1'b0;
      lamp_on <= 1'b0;
    end else begin
      precharge_switch <= psw_nxt;
      precharge_low_power <= lowp_nxt;
      boost1_on <= b1_nxt;
      boost2_on <= b2_nxt;
      boost1_peak <= peak_nxt;
      charge_source_on <= csrc_nxt;
      output_switch <= osw_nxt;
      keep_source_on <= keep_nxt;
      topup_5ma_on <= top5_nxt;
      bleed_resistor_path <= bleed_nxt;
      balancer_on <= bal_nxt;
      lamp_on <= lamp_nxt;
    end
  end

  assign mode_out = mode_r;
  assign state_out = state_r;
  assign fill_rate_out = fill_rate;
  assign full_flag = flag_r;
  assign int_n = !(flag_r && full_irq_enable);
  assign hot_paused = hot_r;
endmodule : scfms_sequencer

// ---- scfms_regs.svh ----
// constants for the supercap charge and flash mode sequencer
`ifndef SCFMS_REGS_SVH
`define SCFMS_REGS_SVH
`define SCFMS_MODE_SHDN_KEEP 3'h0
`define SCFMS_MODE_SHDN_DIS 3'h1
`define SCFMS_MODE_PRECHARGE 3'h2
`define SCFMS_MODE_CHARGE 3'h3
`define SCFMS_MODE_TORCH 3'h4
`define SCFMS_MODE_PWM 3'h5
`define SCFMS_MODE_FLASH 3'h6
`define SCFMS_FILL_LOW_POWER 2'h0
`define SCFMS_PEAK_REDUCED 3'h1
`define SCFMS_FLASH_TIMEOUT_RST 8'h10
`define SCFMS_TIMEOUT_TICK_US 100
`define SCFMS_CLOCK_MHZ 20
`define SCFMS_TICK_CYCLES (`SCFMS_TIMEOUT_TICK_US * `SCFMS_CLOCK_MHZ)
`endif

// ---- scfms_pkg.sv ----
// types of the supercap charge and flash mode sequencer
package scfms_pkg;
  typedef enum logic [3:0] {
    SCFMS_ST_SHDN = 4'h0,
    SCFMS_ST_DISCH = 4'h1,
    SCFMS_ST_PRE_BLEED = 4'h2,
    SCFMS_ST_PRECHARGE = 4'h3,
    SCFMS_ST_TRANSITION = 4'h4,
    SCFMS_ST_CHARGE = 4'h5,
    SCFMS_ST_EOC = 4'h6,
    SCFMS_ST_KEEP = 4'h7,
    SCFMS_ST_TORCH = 4'h8,
    SCFMS_ST_PWM = 4'h9,
    SCFMS_ST_FLASH = 4'hA,
    SCFMS_ST_SHDN_BLEED = 4'hB
  } scfms_state_e;
endpackage : scfms_pkg

// ---- scfms_pwm.sv ----
// lamp current pwm modulator
`timescale 1ns/1ps
module scfms_pwm #(
  parameter int WIDTH = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [WIDTH-1:0] duty,
  output logic lamp_on
);
  initial begin
    if (WIDTH < 2 || WIDTH > 16) $error("scfms_pwm: WIDTH out of range");
  end
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;
  logic on_nxt;
  assign count_nxt = enable ? count_r + {{(WIDTH-1){1'b0}}, 1'b1} : '0;
  assign on_nxt = enable && (count_r < duty);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      lamp_on <= 1'b0;
    end else begin
      count_r <= count_nxt;
      lamp_on <= on_nxt;
    end
  end
endmodule : scfms_pwm

// ---- scfms_timer.sv ----
// flash maximum-duration timer in ticks
`timescale 1ns/1ps
`include "scfms_regs.svh"
module scfms_timer #(
  parameter int TICK_CYCLES = `SCFMS_TICK_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] limit,
  output logic expired
);
  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) $error("scfms_timer: bad TICK_CYCLES");
  end
  logic [15:0] pre_r;
  logic [7:0] ticks_r;
  logic tick;
  assign tick = (pre_r == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= 16'h0000;
      ticks_r <= 8'h00;
      expired <= 1'b0;
    end else if (!run) begin
      pre_r <= 16'h0000;
      ticks_r <= 8'h00;
      expired <= 1'b0;
    end else begin
      pre_r <= tick ? 16'h0000 : pre_r + 16'h0001;
      if (tick && !expired) ticks_r <= ticks_r + 8'h01;
      expired <= (ticks_r >= limit);
    end
  end
endmodule : scfms_timer

// ---- scfms_power_model.sv ----
// behavioural supercap and power stage comparators
`timescale 1ns/1ps
module scfms_power_model #(
  parameter int VIN_MV = 3700,
  parameter int FULL_MV = 5000
) (
  input wire logic clock,
  input wire logic precharge_switch,
  input wire logic charge_source_on,
  input wire logic output_switch,
  input wire logic keep_source_on,
  input wire logic topup_5ma_on,
  input wire logic bleed_resistor_path,
  input wire logic boost2_on,
  output logic cap_near_input,
  output logic cap_at_input,
  output logic cap_at_full,
  output logic cap_below_input_margin,
  output logic cap_over_limit,
  output logic boost_node_high,
  output logic boost_node_low,
  output logic cap_under_flash_min
);
  // cap voltage in mV, also stands for the boost node
  int v_mv = 3000;
  wire fill = charge_source_on || output_switch || keep_source_on || topup_5ma_on ||
    (precharge_switch && v_mv < VIN_MV);
  always @(posedge clock) begin
    if (bleed_resistor_path || boost2_on) v_mv <= v_mv - 10;
    else if (fill) v_mv <= v_mv + 10;
  end
  assign cap_near_input = v_mv >= VIN_MV - 200;
  assign cap_at_input = v_mv >= VIN_MV;
  assign cap_at_full = v_mv >= FULL_MV;
  assign cap_below_input_margin = v_mv < VIN_MV - 300;
  assign cap_over_limit = v_mv > 5500;
  assign boost_node_high = v_mv > 5350;
  assign boost_node_low = v_mv < 5300;
  assign cap_under_flash_min = v_mv < 2550;
endmodule : scfms_power_model

// ---- scfms_sequencer_asserts.sv ----
// port assertions for the supercap mode sequencer
`timescale 1ns/1ps
module scfms_seq_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] post_burst_mode,
  input wire logic [1:0] fill_rate,
  input wire logic balancer_override,
  input wire logic full_irq_enable,
  input wire logic cap_over_limit,
  input wire logic cap_under_flash_min,
  input wire logic hot_die_threshold,
  input wire logic [2:0] mode_out,
  input wire logic [3:0] state_out,
  input wire logic precharge_switch,
  input wire logic precharge_low_power,
  input wire logic boost1_on,
  input wire logic boost2_on,
  input wire logic output_switch,
  input wire logic bleed_resistor_path,
  input wire logic balancer_on,
  input wire logic full_flag,
  input wire logic int_n,
  input wire logic hot_paused
);
  // no heat, pause or over-limit bleed in the last two samples
  logic [1:0] calm_r;
  wire calm = &calm_r && !hot_paused;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) calm_r <= 2'h0;
    else calm_r <= {calm_r[0], !hot_die_threshold && !hot_paused && !cap_over_limit};
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  sequence s_flash_end;
    state_out == scfms_pkg::SCFMS_ST_FLASH ##1 state_out != scfms_pkg::SCFMS_ST_FLASH;
  endsequence
  property p_pre;
    $past(state_out) == scfms_pkg::SCFMS_ST_PRECHARGE && calm |->
      precharge_switch && (precharge_low_power == ($past(fill_rate) == 2'h0));
  endproperty
  a_pre: assert property (p_pre) else $error("bad precharge");
  property p_chg;
    $past(state_out) == scfms_pkg::SCFMS_ST_CHARGE && calm |-> boost1_on && output_switch;
  endproperty
  a_chg: assert property (p_chg) else $error("bad charge");
  property p_int;
    int_n == !(full_flag && full_irq_enable);
  endproperty
  a_int: assert property (p_int) else $error("bad int_n");
  property p_bal;
    $past(state_out) == scfms_pkg::SCFMS_ST_SHDN && calm |->
      balancer_on == $past(balancer_override);
  endproperty
  a_bal: assert property (p_bal) else $error("bad balancer");
  property p_over;
    cap_over_limit |-> ##[1:3] bleed_resistor_path;
  endproperty
  a_over: assert property (p_over) else $error("no bleed");
  property p_hot;
    hot_die_threshold && state_out inside {scfms_pkg::SCFMS_ST_PRECHARGE,
      scfms_pkg::SCFMS_ST_TRANSITION, scfms_pkg::SCFMS_ST_CHARGE} |-> ##[1:2] hot_paused;
  endproperty
  a_hot: assert property (p_hot) else $error("no pause");
  property p_lamp;
    $past(state_out) inside {scfms_pkg::SCFMS_ST_TORCH, scfms_pkg::SCFMS_ST_PWM} |->
      boost1_on && !boost2_on;
  endproperty
  a_lamp: assert property (p_lamp) else $error("bad lamp boost");
  property p_fl;
    $past(state_out) == scfms_pkg::SCFMS_ST_FLASH && !$past(cap_under_flash_min) && calm
      |-> boost1_on && boost2_on;
  endproperty
  a_fl: assert property (p_fl) else $error("bad flash boost");
  property p_low;
    $past(state_out) == scfms_pkg::SCFMS_ST_FLASH && $past(cap_under_flash_min) |->
      boost1_on && !boost2_on;
  endproperty
  a_low: assert property (p_low) else $error("boost two on");
  property p_after;
    s_flash_end |-> ##[0:2] mode_out == {1'b0, post_burst_mode};
  endproperty
  a_after: assert property (p_after) else $error("bad mode after flash");
endmodule : scfms_seq_chk
bind scfms_sequencer scfms_seq_chk chk_u (.clock, .rst_n, .post_burst_mode, .fill_rate,
  .balancer_override, .full_irq_enable, .cap_over_limit, .cap_under_flash_min,
  .hot_die_threshold, .mode_out, .state_out, .precharge_switch, .precharge_low_power,
  .boost1_on, .boost2_on, .output_switch, .bleed_resistor_path, .balancer_on, .full_flag,
  .int_n, .hot_paused);

// ---- testbench.sv ----
// self-checking bench for the supercap mode sequencer
`timescale 1ns/1ps
`include "scfms_regs.svh"
module testbench;
  logic clock = 1'b0, rst_n = 1'b0, mode_write = 1'b0, balancer_override = 1'b0;
  logic maintain_cap_topup = 1'b0, full_irq_enable = 1'b1, full_flag_clear = 1'b0;
  logic flash_stop = 1'b0, hot_die_threshold = 1'b0, hot_die_cleared = 1'b1;
  logic [2:0] mode_in = 3'h0, boost1_inductor_limit = 3'h5, mode_out, boost1_peak;
  logic [1:0] post_burst_mode = 2'h0, fill_rate = 2'h0, fill_rate_out;
  logic [7:0] lamp_duty = 8'h00, flash_max_ticks = 8'h03;
  logic cap_near_input, cap_at_input, cap_at_full, cap_below_input_margin, cap_over_limit;
  logic boost_node_high, boost_node_low, cap_under_flash_min, precharge_switch;
  logic [3:0] state_out;
  logic precharge_low_power, boost1_on, boost2_on, charge_source_on, output_switch;
  logic keep_source_on, topup_5ma_on, bleed_resistor_path, balancer_on, lamp_on;
  logic full_flag, int_n, hot_paused;
  int error_cnt = 0;
  int tests_run = 0;
  int cnt;
  always #25 clock = ~clock;
  scfms_sequencer #(.PWM_WIDTH(8), .TICK_CYCLES(2)) dut_u (.clock, .rst_n, .mode_in,
    .mode_write, .post_burst_mode, .fill_rate, .boost1_inductor_limit, .maintain_cap_topup,
    .balancer_override, .full_irq_enable, .full_flag_clear, .lamp_duty, .flash_max_ticks,
    .cap_near_input, .cap_at_input, .cap_at_full, .cap_below_input_margin, .cap_over_limit,
    .boost_node_high, .boost_node_low, .cap_under_flash_min, .hot_die_threshold,
    .hot_die_cleared, .flash_stop, .mode_out, .state_out, .precharge_switch,
    .precharge_low_power, .fill_rate_out, .boost1_on, .boost2_on, .boost1_peak,
    .charge_source_on, .output_switch, .keep_source_on, .topup_5ma_on, .bleed_resistor_path,
    .balancer_on, .lamp_on, .full_flag, .int_n, .hot_paused);
  scfms_power_model pm_u (.clock, .precharge_switch, .charge_source_on, .output_switch,
    .keep_source_on, .topup_5ma_on, .bleed_resistor_path, .boost2_on, .cap_near_input,
    .cap_at_input, .cap_at_full, .cap_below_input_margin, .cap_over_limit,
    .boost_node_high, .boost_node_low, .cap_under_flash_min);
  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  task automatic set_mode(input logic [2:0] m);
    mode_in = m;
    mode_write = 1'b1;
    tick(1);
    mode_write = 1'b0;
  endtask : set_mode
  // bounded wait on state (or mode when on_mode); a timeout ends the run
  task automatic wait_for(input logic on_mode, input logic [3:0] exp, input int lim);
    logic [3:0] cur;
    for (int i = 0; i < lim; i++) begin
      cur = on_mode ? {1'b0, mode_out} : state_out;
      if (cur === exp) return;
      tick(1);
    end
    chk_val(cur, exp);
    stop_test();
  endtask : wait_for
  initial begin
    tick(2);
    rst_n = 1'b1;
    tick(1);
    chk_val(state_out, scfms_pkg::SCFMS_ST_SHDN);
    pm_u.v_mv = 3600;
    set_mode(`SCFMS_MODE_PRECHARGE);
    wait_for(1'b0, scfms_pkg::SCFMS_ST_PRECHARGE, 10);
    tick(2);
    chk_bit(precharge_switch, 1'b1);
    chk_bit(precharge_low_power, 1'b1);
    chk_val({2'h0, fill_rate_out}, 4'h0);
    hot_die_threshold = 1'b1;
    hot_die_cleared = 1'b0;
    tick(3);
    chk_bit(hot_paused, 1'b1);
    hot_die_threshold = 1'b0;
    tick(3);
    chk_bit(hot_paused, 1'b1);
    hot_die_cleared = 1'b1;
    tick(3);
    chk_bit(hot_paused, 1'b0);
    maintain_cap_topup = 1'b1;
    set_mode(`SCFMS_MODE_CHARGE);
    wait_for(1'b0, scfms_pkg::SCFMS_ST_CHARGE, 400);
    tick(2);
    chk_bit(output_switch, 1'b1);
    wait_for(1'b0, scfms_pkg::SCFMS_ST_EOC, 400);
    tick(1);
    chk_bit(full_flag, 1'b1);
    chk_bit(int_n, 1'b0);
    wait_for(1'b0, scfms_pkg::SCFMS_ST_KEEP, 20);
    pm_u.v_mv = 4900;
    tick(3);
    chk_bit(topup_5ma_on, 1'b1);
    full_flag_clear = 1'b1;
    tick(1);
    full_flag_clear = 1'b0;
    tick(1);
    chk_bit(int_n, 1'b1);
    for (int pb = 0; pb < 4; pb++) begin
      pm_u.v_mv = (pb == 1) ? 2500 : 5000;
      post_burst_mode = 2'(pb);
      set_mode(`SCFMS_MODE_FLASH);
      wait_for(1'b0, scfms_pkg::SCFMS_ST_FLASH, 10);
      tick(2);
      chk_bit(boost2_on, pb != 1);
      chk_bit(boost1_on, 1'b1);
      flash_stop = (pb == 3);
      wait_for(1'b1, 4'(pb), 40);
      flash_stop = 1'b0;
      tick(4);
      chk_bit(bleed_resistor_path, pb == 1 || pb == 2);
    end
    pm_u.v_mv = 4000;
    set_mode(`SCFMS_MODE_TORCH);
    wait_for(1'b0, scfms_pkg::SCFMS_ST_TORCH, 10);
    tick(2);
    chk_bit(boost2_on, 1'b0);
    chk_bit(lamp_on, 1'b1);
    chk_bit(keep_source_on, 1'b1);
    for (int d = 0; d < 2; d++) begin
      lamp_duty = d ? 8'h80 : 8'h00;
      set_mode(`SCFMS_MODE_PWM);
      wait_for(1'b0, scfms_pkg::SCFMS_ST_PWM, 10);
      cnt = 0;
      repeat (512) begin
        tick(1);
        if (lamp_on === 1'b1) cnt++;
      end
      chk_bit(d ? (cnt > 0 && cnt < 512) : (cnt == 0), 1'b1);
    end
    pm_u.v_mv = 5600;
    set_mode(`SCFMS_MODE_SHDN_KEEP);
    tick(4);
    chk_bit(bleed_resistor_path, 1'b1);
    wait_for(1'b0, scfms_pkg::SCFMS_ST_SHDN, 100);
    tick(2);
    chk_bit(balancer_on, 1'b0);
    balancer_override = 1'b1;
    tick(2);
    chk_bit(balancer_on, 1'b1);
    stop_test();
  end
endmodule : testbench
